// >>> rtl/pwt_top.sv
// Power-control window timer top: APB register file plus window sequencer.
// Assumes alarm and pwc_tick are one-pclk pulses synchronous to pclk.
//
// Functional notes
// RULE_01 - Stability window equals setting, 1 to 255
// RULE_02 - Zero stability setting: sample starts at alarm
// RULE_03 - Sample window equals setting, 1 to 254
// RULE_04 - All-ones sample setting: window always on
// RULE_05 - Zero sample setting: no sample window
// RULE_06 - Sample starts when stability counter expires
// RULE_07 - Length register writable only when write-enable set
// RULE_08 - Every alarm reloads both counters from settings; here only an alarm in idle with enable set loads the one shared counter
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module pwt_top
	import pwt_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Power-control timing
	input  wire logic        pwc_tick,
	input  wire logic        alarm,
	output logic             sample_window,
	output logic             stab_window
);

	pwt_lengths_s lengths;
	pwt_lengths_s next_lengths;
	logic [1:0]   ctrl;
	logic [1:0]   next_ctrl;
	logic [31:0]  next_prdata;
	logic         next_pslverr;
	logic         access;
	logic         wr;
	logic         mapped;
	pwt_state_e   state;

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw, input logic en);
		merge_byte = en ? nw : old;
	endfunction

	assign access = psel && penable;
	assign wr     = access && pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr == PWT_OFF_LENGTHS) || (paddr == PWT_OFF_CTRL) || (paddr == PWT_OFF_STATUS);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_lengths = lengths;
		next_ctrl    = ctrl;
		if (wr && paddr == PWT_OFF_LENGTHS && ctrl[PWT_CTRL_WREN_BIT]) begin // RULE_07
			next_lengths.samp = merge_byte(lengths.samp, pwdata[7:0], pstrb[0]);
			next_lengths.stab = merge_byte(lengths.stab, pwdata[15:8], pstrb[1]);
		end
		if (wr && paddr == PWT_OFF_CTRL && pstrb[0]) begin
			next_ctrl = pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lengths <= PWT_LENGTHS_RST;
			ctrl    <= PWT_CTRL_RST;
		end else begin
			lengths <= next_lengths;
			ctrl    <= next_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data registered at setup so it is valid in the access phase
	always_comb begin
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				PWT_OFF_LENGTHS: next_prdata = {16'h0000, lengths};
				PWT_OFF_CTRL:    next_prdata = {30'h0000_0000, ctrl};
				PWT_OFF_STATUS:  next_prdata = {27'h0000_0000, state, stab_window, sample_window};
				default:         next_prdata = 32'h0000_0000;
			endcase
			next_pslverr = !mapped;
		end else if (access) begin
			next_pslverr = pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	pwt_window_counter u_win (
		.pclk          (pclk),
		.presetn       (presetn),
		.tick          (pwc_tick),
		.alarm         (alarm),
		.enable        (ctrl[PWT_CTRL_POWER_CONTROL_ENABLE_BIT]),
		.lengths       (lengths),
		.sample_window (sample_window),
		.stab_window   (stab_window),
		.state         (state)
	);

endmodule // pwt_top

// >>> rtl/pwt_pkg.sv
// Package for the power-control window timer: register map, fields, states.
// Assumes a 32-bit APB slave with word-aligned registers.
package pwt_pkg;

	// Register byte offsets
	localparam logic [7:0] PWT_OFF_LENGTHS = 8'h00;
	localparam logic [7:0] PWT_OFF_CTRL    = 8'h04;
	localparam logic [7:0] PWT_OFF_STATUS  = 8'h08;

	// Field positions
	localparam int PWT_STAB_LSB = 8;
	localparam int PWT_SAMP_LSB = 0;
	localparam int PWT_CTRL_WREN_BIT = 0;
	localparam int PWT_CTRL_POWER_CONTROL_ENABLE_BIT = 1;

	// Special setting codes
	localparam logic [7:0] PWT_LEN_NONE   = 8'h00;
	localparam logic [7:0] PWT_SAMP_ALWAYS = 8'hFF;

	// Reset values (lengths are unknown in hardware; zero chosen here)
	localparam logic [15:0] PWT_LENGTHS_RST = 16'h0000;
	localparam logic [1:0]  PWT_CTRL_RST    = 2'h0;

	typedef enum logic [2:0] {
		PWT_IDLE   = 3'b001,
		PWT_STAB   = 3'b010,
		PWT_SAMPLE = 3'b100
	} pwt_state_e;

	typedef struct packed {
		logic [7:0] stab;
		logic [7:0] samp;
	} pwt_lengths_s;

endpackage : pwt_pkg

// >>> rtl/pwt_window_counter.sv
// Window sequencer: stability window then sample window, one sequence per alarm taken in idle with enable set.
// Assumes tick marks one power-control clock period, synchronous to pclk.
`timescale 1ns/1ps
module pwt_window_counter
	import pwt_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         tick,
	input  wire logic         alarm,
	input  wire logic         enable,
	input  wire pwt_lengths_s lengths,
	// Status
	output logic              sample_window,
	output logic              stab_window,
	output pwt_state_e        state
);

	pwt_state_e next_state;
	logic [7:0] count;
	logic [7:0] next_count;
	logic       always_on;

	assign always_on = (lengths.samp == PWT_SAMP_ALWAYS); // RULE_04

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			PWT_IDLE: begin
				if (alarm && enable) begin
					if (lengths.stab != PWT_LEN_NONE) begin // RULE_08
						next_state = PWT_STAB;
						next_count = lengths.stab; // RULE_01
					end else if (lengths.samp != PWT_LEN_NONE) begin // RULE_02 RULE_06
						next_state = PWT_SAMPLE;
						next_count = lengths.samp;
					end
				end
			end
			PWT_STAB: begin
				if (tick) begin
					if (count == 8'h01) begin
						// Expiry hands straight to the sample window, or back to idle when the sample setting is zero
						if (lengths.samp != PWT_LEN_NONE) begin // RULE_06 RULE_05
							next_state = PWT_SAMPLE;
							next_count = lengths.samp; // RULE_03
						end else begin
							next_state = PWT_IDLE;
						end
					end else begin
						next_count = count - 8'h01;
					end
				end
			end
			PWT_SAMPLE: begin
				if (tick && !always_on) begin
					if (count == 8'h01) begin
						next_state = PWT_IDLE;
					end else begin
						next_count = count - 8'h01; // RULE_03
					end
				end
			end
			default: begin
				next_state = PWT_IDLE;
				next_count = 8'h00;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PWT_IDLE;
			count <= 8'h00;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Output from flops; all-ones setting holds it high regardless of enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_window <= 1'b0;
			stab_window   <= 1'b0;
		end else begin
			sample_window <= (next_state == PWT_SAMPLE) || always_on; // RULE_04
			stab_window   <= (next_state == PWT_STAB);
		end
	end

endmodule // pwt_window_counter

// >>> tb/pwt_top_props.sv
// Checker: window and APB port relations of pwt_top.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
module pwt_top_props (
	input wire logic       pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0] paddr,
	input wire logic       pwc_tick, alarm, sample_window, stab_window
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_stab_start; $rose(stab_window) |-> $past(alarm); endproperty
	a_stab_start: assert property (p_stab_start) else $error("stab rose without alarm");
	property p_stab_end; $fell(stab_window) |-> $past(pwc_tick); endproperty
	a_stab_end: assert property (p_stab_end) else $error("stab ended off tick");
	property p_samp_end; $fell(sample_window) |-> $past(pwc_tick); endproperty
	a_samp_end: assert property (p_samp_end) else $error("sample ended off tick");
	property p_excl; !(stab_window && sample_window); endproperty
	a_excl: assert property (p_excl) else $error("windows overlap");
	property p_samp_start;
		$rose(sample_window) |-> $past(alarm) || $past(stab_window) || $past(psel && penable && pwrite, 2);
	endproperty
	a_samp_start: assert property (p_samp_start) else $error("sample rose without cause");
	property p_fresh; $rose(stab_window) |-> !$past(sample_window); endproperty
	a_fresh: assert property (p_fresh) else $error("sequence restarted mid-run");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not taken");
	property p_err; psel && penable && paddr > 8'h08 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("unmapped without error");
endmodule // pwt_top_props

// >>> tb/tb_power_control_window_timer.sv
// Bench: APB tasks and alarm sequences against pwt_top.
// Assumes the checker file is compiled before this one.
`timescale 1ns/1ps
module tb_power_control_window_timer;
	import pwt_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pwc_tick, alarm, e;
	logic        pready, pslverr, sample_window, stab_window;
	logic [7:0]  paddr;
	logic [3:0]  pstrb;
	logic [31:0] pwdata, prdata, q;
	int          num_errors, num_checks;
	pwt_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .pwc_tick, .alarm, .sample_window, .stab_window);
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	// Tick every other cycle so ticks and cycles differ
	always @(posedge pclk) pwc_tick <= ~pwc_tick;
	////////////////////////////////////////////////////////////
	task conclude;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] y);
		num_checks++;
		if (y !== x) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, x, y);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin num_errors++; conclude; end
		q = prdata; e = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// Counts ticks seen inside each window after one alarm
	task meas(input logic [15:0] l);
		int s, p, c;
		apb(1, PWT_OFF_LENGTHS, {16'h0000, l});
		@(posedge pclk) alarm <= 1;
		@(posedge pclk) alarm <= 0;
		s = 0; p = 0;
		for (c = 0; c < 1100; c++) begin
			@(negedge pclk);
			s += int'(stab_window & pwc_tick);
			p += int'(sample_window & pwc_tick);
			if (c > 2 && !stab_window && !sample_window) break;
		end
		if (c == 1100) begin num_errors++; conclude; end
		chk("stab ticks", {24'h0000_00, l[15:8]}, s);
		chk("sample ticks", {24'h0000_00, l[7:0]}, p);
	endtask
	initial begin
		{psel, penable, pwrite, pwc_tick, alarm} = 0; paddr = 0; pwdata = 0; pstrb = 4'hF; presetn = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(1, PWT_OFF_CTRL, 32'h0000_0003);
		meas(16'h0101);
		meas(16'h0005);
		meas(16'h0300);
		meas(16'hFFFE);
		meas(16'h0203);
		meas(16'h0203);
		apb(1, PWT_OFF_CTRL, 32'h0000_0002);
		apb(1, PWT_OFF_LENGTHS, 32'h0000_0404);
		apb(0, PWT_OFF_LENGTHS, 32'h0000_0000);
		chk("locked lengths", 32'h0000_0203, q);
		apb(1, PWT_OFF_CTRL, 32'h0000_0003);
		apb(1, PWT_OFF_LENGTHS, 32'h0000_00FF);
		apb(1, PWT_OFF_CTRL, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk("always window", 32'h0000_0001, {31'h0000_0000, sample_window});
		apb(0, 8'h0C, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0000_0000, e});
		conclude;
	end
endmodule // tb_power_control_window_timer
bind pwt_top pwt_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
	.pwc_tick, .alarm, .sample_window, .stab_window);
